// file: src/fcp_pkg.sv
`default_nettype none
package fcp_pkg;

  // ------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------
  localparam int unsigned FCP_ADDR_W = 10;
  localparam int unsigned FCP_DATA_W = 32;
  localparam int unsigned FCP_PRES_W = 7;

  // ------------------------------------------------------------
  // register indices, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [7:0] FCP_IDX_CLK   = 8'h40;
  localparam logic [7:0] FCP_IDX_POL   = 8'h41;
  localparam logic [7:0] FCP_IDX_EN    = 8'h42;
  localparam logic [7:0] FCP_IDX_PRES  = 8'h43;
  localparam logic [7:0] FCP_IDX_SCAL0 = 8'h44;
  localparam logic [7:0] FCP_IDX_SCNT0 = 8'h45;
  localparam logic [7:0] FCP_IDX_SCAL1 = 8'h46;
  localparam logic [7:0] FCP_IDX_SCNT1 = 8'h47;
  localparam logic [7:0] FCP_IDX_CNT   = 8'h48;
  localparam logic [7:0] FCP_IDX_PER   = 8'h4c;
  localparam logic [7:0] FCP_IDX_DTY   = 8'h50;
  localparam logic [7:0] FCP_IDX_CTL   = 8'h54;
  localparam logic [7:0] FCP_IDX_TST   = 8'h55;
  localparam logic [7:0] FCP_IDX_PDATA = 8'h56;
  localparam logic [7:0] FCP_IDX_DDR   = 8'h57;
  localparam logic [7:0] FCP_IDX_LAST  = 8'h57;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int unsigned FCP_CLK_JOIN_UPPER = 7;
  localparam int unsigned FCP_CLK_JOIN_LOWER = 6;
  localparam int unsigned FCP_CLK_A_LSB      = 3;
  localparam int unsigned FCP_CLK_B_LSB      = 0;
  localparam int unsigned FCP_POL_SEL_LSB    = 4;
  localparam int unsigned FCP_POL_POL_LSB    = 0;
  localparam int unsigned FCP_CTL_CENTER     = 3;
  localparam int unsigned FCP_TST_DISCR      = 5;
  localparam int unsigned FCP_TST_DISCP      = 4;
  localparam int unsigned FCP_TST_SCALE_LOAD_INHIBIT     = 3;
  localparam logic [7:0]  FCP_TST_MASK       = 8'h38;
  localparam logic [7:0]  FCP_CTL_MASK       = 8'h08;
  localparam logic [7:0]  FCP_EN_MASK        = 8'h0f;
  localparam logic [7:0]  FCP_RST_BYTE       = 8'h00;

  // per-pair configuration carried into the channel pair
  typedef struct packed {
    logic       concat;
    logic       center;
    logic [1:0] pol;
    logic       discr;
    logic       discp;
  } fcp_pair_cfg_t;

endpackage
`default_nettype wire

// file: src/fcp_pair.sv
`default_nettype none
module fcp_pair
  import fcp_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire fcp_pair_cfg_t cfg,
  input  wire logic [1:0]    tick,
  input  wire logic [1:0]    on,
  input  wire logic [1:0]    per_wr,
  input  wire logic [1:0]    dty_wr,
  input  wire logic [1:0]    cnt_wr,
  input  wire logic [7:0]    wdata,
  output logic      [15:0]   cnt_q,
  output logic      [15:0]   per_q,
  output logic      [15:0]   dty_q,
  output logic      [1:0]    wave_q,
  output logic      [1:0]    drive_q
);

  // lane 1 is the high byte channel, lane 0 the low byte channel
  logic [1:0][7:0]  cnt_r, per_buf_r, per_act_r, dty_buf_r, dty_act_r;
  logic [1:0]       down_r, run_r;
  logic [1:0][15:0] nxt;
  logic [1:0]       en_eff, tk, roll, dn_nxt, wav, pol_eff, cwr, ld;
  logic [15:0]      c16, p16, d16;
  logic             chg;

  // ------------------------------------------------------------
  // next count and waveform, per lane or joined
  // ------------------------------------------------------------
  always_comb begin
    c16 = '0;
    p16 = '0;
    d16 = '0;
    chg = 1'b0;
    for (int k = 0; k < 2; k++) begin
      // joined pair runs on the low channel clock, high channel enable
      en_eff[k]  = cfg.concat ? on[1] : on[k];
      tk[k]      = cfg.concat ? tick[0] : tick[k];
      pol_eff[k] = cfg.concat ? cfg.pol[1] : cfg.pol[k];
      cwr[k]     = cfg.concat ? (|cnt_wr) : cnt_wr[k];
      c16 = cfg.concat ? {cnt_r[1], cnt_r[0]} : {8'h00, cnt_r[k]};
      p16 = cfg.concat ? {per_act_r[1], per_act_r[0]} : {8'h00, per_act_r[k]};
      d16 = cfg.concat ? {dty_act_r[1], dty_act_r[0]} : {8'h00, dty_act_r[k]};
      roll[k]   = 1'b0;
      dn_nxt[k] = down_r[k];
      nxt[k]    = c16 + 16'h0001;
      if (!cfg.center) begin
        dn_nxt[k] = 1'b0;
        if (c16 >= p16 && !cfg.discp) begin
          nxt[k]  = '0;
          roll[k] = 1'b1;
        end
      end else if (!down_r[k]) begin
        if (c16 >= p16) begin
          dn_nxt[k] = 1'b1;
          nxt[k]    = (c16 == 16'h0000) ? 16'h0000 : c16 - 16'h0001;
        end
      end else if (c16 == 16'h0000) begin
        dn_nxt[k] = 1'b0;
        roll[k]   = 1'b1;
      end else begin
        nxt[k] = c16 - 16'h0001;
      end
      chg = cfg.center ? (c16 >= d16 && d16 < p16) : (c16 > d16 && d16 < p16);
      wav[k] = pol_eff[k] ^ chg;
    end
    // latch buffers on rollover or while disabled
    for (int k = 0; k < 2; k++) begin
      // joined pair follows the high lane roll, only known after the loop
      ld[k] = !en_eff[k] || cwr[k]
              || (tk[k] && run_r[k] && (cfg.concat ? roll[1] : roll[k]));
    end
  end

  // ------------------------------------------------------------
  // counters, clock gate and waveform
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r  <= '0;
      down_r <= '0;
      run_r  <= '0;
      wave_q <= '0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        // gate follows enable only at a clock edge
        if (tk[k]) begin
          run_r[k] <= en_eff[k];
        end
        if (cwr[k]) begin
          if (!cfg.discr) begin
            cnt_r[k]  <= '0;
            down_r[k] <= 1'b0;
          end
        end else if (tk[k] && run_r[k]) begin
          cnt_r[k]  <= cfg.concat ? nxt[1][8*k +: 8] : nxt[k][7:0];
          down_r[k] <= cfg.concat ? dn_nxt[1] : dn_nxt[k];
        end
        // waveform shows once the gated clock runs
        wave_q[k] <= run_r[k] ? (cfg.concat ? wav[1] : wav[k]) : pol_eff[k];
      end
    end
  end

  // ------------------------------------------------------------
  // double-buffered period and duty
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_buf_r <= '0;
      per_act_r <= '0;
      dty_buf_r <= '0;
      dty_act_r <= '0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (per_wr[k]) begin
          per_buf_r[k] <= wdata;
        end
        if (dty_wr[k]) begin
          dty_buf_r[k] <= wdata;
        end
        // disabled writes reach the working latch directly
        if (ld[k]) begin
          per_act_r[k] <= per_wr[k] ? wdata : per_buf_r[k];
          dty_act_r[k] <= dty_wr[k] ? wdata : dty_buf_r[k];
        end
      end
    end
  end

  // pin ownership, low lane pin is free while joined
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_q <= '0;
    end else begin
      drive_q <= {on[1], on[0] & ~cfg.concat};
    end
  end

  assign cnt_q = {cnt_r[1], cnt_r[0]};
  assign per_q = {per_buf_r[1], per_buf_r[0]};
  assign dty_q = {dty_buf_r[1], dty_buf_r[0]};

endmodule
`default_nettype wire

// file: src/fcp_top.sv
// Contract
// - four 8-bit channels, or pairs joined as 16-bit, each own counter.
// - enabled channel holds new period/duty until rollover or disable.
// - disabled channel write updates buffer and working latch together.
// - counter write clears the counter and latches pending period and duty.
// - enabled channel drives its shared pin; unused pins stay general purpose.
// - upper join: ch2 high byte, ch3 low, out on pin 2, ch3 clock.
// - lower join: ch0 high byte, ch1 low, out on pin 0, ch1 clock.
// - two 3-bit fields pick clock A and B as E over 2 to n.
// - clock select bit picks prescaled clock at 0, scaled clock at 1.
// - polarity 1 starts high then low at duty; 0 the reverse.
// - left aligned, duty counts low time at polarity 0, high at 1.
// - enable forces pin to output without touching the direction bit.
// - prescaler counter stops when all four enables are clear.
// - channel clock gated on or off only at a clock edge.
// - waveform appears when the channel clock begins its next cycle.
// - prescale counter free runs 7 bits, writable only in special mode.
// - scale write loads scale counter unless special mode load inhibit.
// - scaled clocks are clock A (S0) or B (S1) over scale plus one, then over two.
// - scale counter counts down and reloads scale value at zero.
// - center aligned counter counts up and down, turning on period match.
//
// Our own choice: the APB slave port.
`default_nettype none
module fcp_top
  import fcp_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [FCP_ADDR_W-1:0] paddr,
  input  wire logic [FCP_DATA_W-1:0] pwdata,
  output logic                       pready,
  output logic      [FCP_DATA_W-1:0] prdata,
  output logic                       pslverr,
  input  wire logic                  special_mode_flag,
  input  wire logic [3:0]            port_in,
  output logic      [3:0]            port_out,
  output logic      [3:0]            port_oe
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------

  // clock A/B tick: low n prescaler bits all ones
  function automatic logic fcp_clk_tick(input logic [FCP_PRES_W-1:0] pres,
                                        input logic [2:0] sel,
                                        input logic run);
    logic [FCP_PRES_W-1:0] mask;
    mask = FCP_PRES_W'((8'h01 << sel) - 8'h01);
    return run && ((pres & mask) == mask);
  endfunction

  // write strobe for one register index
  function automatic logic fcp_hit_idx(input logic [7:0] idx,
                                       input logic [7:0] want,
                                       input logic go);
    return go && (idx == want);
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0]            clk_r, pol_r, en_r, ctl_r, tst_r, pdata_r, ddr_r;
  logic [FCP_PRES_W-1:0] pres_r;
  logic [1:0][7:0]       scal_r, scnt_r;
  logic [1:0]            half_r;

  logic [7:0]            idx;
  logic                  hit, acc, wr_en;
  logic [7:0]            wd, rd_val;
  logic                  run_any, tick_a, tick_b;
  logic [1:0]            s_tick;
  logic [3:0]            ch_tick, cnt_wr_c, per_wr_c, dty_wr_c;
  logic [1:0][15:0]      cnt_q, per_q, dty_q;
  logic [1:0][1:0]       wave_q, drive_q;
  logic [3:0]            ch_wave, ch_drive;
  fcp_pair_cfg_t         cfg_lo, cfg_hi;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign idx   = paddr[9:2];
  assign hit   = (paddr[1:0] == 2'b00) && (idx >= FCP_IDX_CLK) && (idx <= FCP_IDX_LAST);
  assign acc   = psel && penable && pready;
  // write lands at the single access edge
  assign wr_en = acc && pwrite && hit;
  assign wd    = pwdata[7:0];

  // one wait-free access phase per transfer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (psel && !penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !hit;
      prdata  <= {24'h000000, (hit && !pwrite) ? rd_val : 8'h00};
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // read mux, reserved bits read zero
  always_comb begin
    rd_val = 8'h00;
    case (idx)
      FCP_IDX_CLK:   rd_val = clk_r;
      FCP_IDX_POL:   rd_val = pol_r;
      FCP_IDX_EN:    rd_val = en_r;
      FCP_IDX_PRES:  rd_val = {1'b0, pres_r};
      FCP_IDX_SCAL0: rd_val = scal_r[0];
      FCP_IDX_SCNT0: rd_val = scnt_r[0];
      FCP_IDX_SCAL1: rd_val = scal_r[1];
      FCP_IDX_SCNT1: rd_val = scnt_r[1];
      FCP_IDX_CTL:   rd_val = ctl_r;
      FCP_IDX_TST:   rd_val = tst_r;
      // input pins read the pin level, outputs read the latch
      FCP_IDX_PDATA: rd_val = {4'h0, (ddr_r[3:0] & pdata_r[3:0]) | (~ddr_r[3:0] & port_in)};
      FCP_IDX_DDR:   rd_val = ddr_r;
      default: begin
        if (idx >= FCP_IDX_CNT && idx < FCP_IDX_PER) begin
          rd_val = idx[1] ? cnt_q[1][{~idx[0], 3'b000} +: 8]
                          : cnt_q[0][{~idx[0], 3'b000} +: 8];
        end else if (idx >= FCP_IDX_PER && idx < FCP_IDX_DTY) begin
          rd_val = idx[1] ? per_q[1][{~idx[0], 3'b000} +: 8]
                          : per_q[0][{~idx[0], 3'b000} +: 8];
        end else if (idx >= FCP_IDX_DTY && idx < FCP_IDX_CTL) begin
          rd_val = idx[1] ? dty_q[1][{~idx[0], 3'b000} +: 8]
                          : dty_q[0][{~idx[0], 3'b000} +: 8];
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_r   <= FCP_RST_BYTE;
      pol_r   <= FCP_RST_BYTE;
      en_r    <= FCP_RST_BYTE;
      ctl_r   <= FCP_RST_BYTE;
      pdata_r <= FCP_RST_BYTE;
      ddr_r   <= FCP_RST_BYTE;
    end else begin
      if (fcp_hit_idx(idx, FCP_IDX_CLK, wr_en)) begin
        clk_r <= wd;
      end
      if (fcp_hit_idx(idx, FCP_IDX_POL, wr_en)) begin
        pol_r <= wd;
      end
      if (fcp_hit_idx(idx, FCP_IDX_EN, wr_en)) begin
        en_r <= wd & FCP_EN_MASK;
      end
      if (fcp_hit_idx(idx, FCP_IDX_CTL, wr_en)) begin
        ctl_r <= wd & FCP_CTL_MASK;
      end
      if (fcp_hit_idx(idx, FCP_IDX_PDATA, wr_en)) begin
        pdata_r <= wd & FCP_EN_MASK;
      end
      if (fcp_hit_idx(idx, FCP_IDX_DDR, wr_en)) begin
        ddr_r <= wd & FCP_EN_MASK;
      end
    end
  end

  // test bits exist only in special mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tst_r <= FCP_RST_BYTE;
    end else if (!special_mode_flag) begin
      tst_r <= FCP_RST_BYTE;
    end else if (fcp_hit_idx(idx, FCP_IDX_TST, wr_en)) begin
      tst_r <= wd & FCP_TST_MASK;
    end
  end

  // ------------------------------------------------------------
  // prescaler and clocks A, B
  // ------------------------------------------------------------
  // prescaler idles with every channel off
  assign run_any = |en_r[3:0];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pres_r <= '0;
    end else if (special_mode_flag && fcp_hit_idx(idx, FCP_IDX_PRES, wr_en)) begin
      pres_r <= wd[FCP_PRES_W-1:0];
    end else if (run_any) begin
      pres_r <= pres_r + 7'h01;
    end
  end

  assign tick_a = fcp_clk_tick(pres_r, clk_r[FCP_CLK_A_LSB +: 3], run_any);
  assign tick_b = fcp_clk_tick(pres_r, clk_r[FCP_CLK_B_LSB +: 3], run_any);

  // ------------------------------------------------------------
  // scale counters, S0 from clock A, S1 from clock B
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scal_r <= '0;
      scnt_r <= '0;
      half_r <= '0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (fcp_hit_idx(idx, s[0] ? FCP_IDX_SCAL1 : FCP_IDX_SCAL0, wr_en)) begin
          scal_r[s] <= wd;
        end
        if (fcp_hit_idx(idx, s[0] ? FCP_IDX_SCAL1 : FCP_IDX_SCAL0, wr_en)
            && !(special_mode_flag && tst_r[FCP_TST_SCALE_LOAD_INHIBIT])) begin
          scnt_r[s] <= wd;
        end else if (s[0] ? tick_b : tick_a) begin
          if (scnt_r[s] == 8'h00) begin
            scnt_r[s] <= scal_r[s];
            half_r[s] <= ~half_r[s];
          end else begin
            scnt_r[s] <= scnt_r[s] - 8'h01;
          end
        end
      end
    end
  end

  // every second reload gives one scaled tick
  assign s_tick[0] = tick_a && (scnt_r[0] == 8'h00) && half_r[0];
  assign s_tick[1] = tick_b && (scnt_r[1] == 8'h00) && half_r[1];

  // ------------------------------------------------------------
  // channel clocks and write strobes
  // ------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      // prescaled or scaled clock per channel
      if (c < 2) begin
        ch_tick[c] = pol_r[FCP_POL_SEL_LSB + c] ? s_tick[0] : tick_a;
      end else begin
        ch_tick[c] = pol_r[FCP_POL_SEL_LSB + c] ? s_tick[1] : tick_b;
      end
      cnt_wr_c[c] = fcp_hit_idx(idx, FCP_IDX_CNT + 8'(c), wr_en);
      per_wr_c[c] = fcp_hit_idx(idx, FCP_IDX_PER + 8'(c), wr_en);
      dty_wr_c[c] = fcp_hit_idx(idx, FCP_IDX_DTY + 8'(c), wr_en);
    end
  end

  // lower pair joins ch0 high and ch1 low
  assign cfg_lo = '{concat: clk_r[FCP_CLK_JOIN_LOWER],
                    center: ctl_r[FCP_CTL_CENTER],
                    pol:    {pol_r[FCP_POL_POL_LSB], pol_r[FCP_POL_POL_LSB + 1]},
                    discr:  tst_r[FCP_TST_DISCR],
                    discp:  tst_r[FCP_TST_DISCP]};
  // upper pair joins ch2 high and ch3 low
  assign cfg_hi = '{concat: clk_r[FCP_CLK_JOIN_UPPER],
                    center: ctl_r[FCP_CTL_CENTER],
                    pol:    {pol_r[FCP_POL_POL_LSB + 2], pol_r[FCP_POL_POL_LSB + 3]},
                    discr:  tst_r[FCP_TST_DISCR],
                    discp:  tst_r[FCP_TST_DISCP]};

  // ------------------------------------------------------------
  // channel pairs, lane 1 is the even channel
  // ------------------------------------------------------------
  fcp_pair u_pair_lo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cfg     (cfg_lo),
    .tick    ({ch_tick[0], ch_tick[1]}),
    .on      ({en_r[0], en_r[1]}),
    .per_wr  ({per_wr_c[0], per_wr_c[1]}),
    .dty_wr  ({dty_wr_c[0], dty_wr_c[1]}),
    .cnt_wr  ({cnt_wr_c[0], cnt_wr_c[1]}),
    .wdata   (wd),
    .cnt_q   (cnt_q[0]),
    .per_q   (per_q[0]),
    .dty_q   (dty_q[0]),
    .wave_q  (wave_q[0]),
    .drive_q (drive_q[0])
  );

  fcp_pair u_pair_hi (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cfg     (cfg_hi),
    .tick    ({ch_tick[2], ch_tick[3]}),
    .on      ({en_r[2], en_r[3]}),
    .per_wr  ({per_wr_c[2], per_wr_c[3]}),
    .dty_wr  ({dty_wr_c[2], dty_wr_c[3]}),
    .cnt_wr  ({cnt_wr_c[2], cnt_wr_c[3]}),
    .wdata   (wd),
    .cnt_q   (cnt_q[1]),
    .per_q   (per_q[1]),
    .dty_q   (dty_q[1]),
    .wave_q  (wave_q[1]),
    .drive_q (drive_q[1])
  );

  assign ch_wave  = {wave_q[1][0], wave_q[1][1], wave_q[0][0], wave_q[0][1]};
  assign ch_drive = {drive_q[1][0], drive_q[1][1], drive_q[0][0], drive_q[0][1]};

  // ------------------------------------------------------------
  // shared port pins
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_out <= '0;
      port_oe  <= '0;
    end else begin
      // channel output overrides the port latch
      port_out <= (ch_drive & ch_wave) | (~ch_drive & pdata_r[3:0]);
      port_oe  <= ch_drive | ddr_r[3:0];
    end
  end

endmodule
`default_nettype wire

// file: dv/fcp_chk.sv
`default_nettype none
module fcp_chk
  import fcp_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [FCP_ADDR_W-1:0] paddr,
  input wire logic [FCP_DATA_W-1:0] pwdata,
  input wire logic                  pready,
  input wire logic [FCP_DATA_W-1:0] prdata,
  input wire logic                  pslverr,
  input wire logic                  special_mode_flag,
  input wire logic [3:0]            port_in,
  input wire logic [3:0]            port_out,
  input wire logic [3:0]            port_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // bus and pin checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic setup;
  logic bad;
  // setup edge and refused address
  assign setup = psel && !penable && !pready;
  assign bad   = paddr[1:0] != 2'b00 || paddr[9:2] < FCP_IDX_CLK || paddr[9:2] > FCP_IDX_LAST;
  AST_READY_NEXT: assert property (setup |=> pready)
    else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_READY_IDLE: assert property (!psel |=> !pready)
    else $error("ready without request");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_ERR_BAD: assert property (setup && bad |=> pslverr)
    else $error("bad address accepted");
  AST_ERR_GOOD: assert property (setup && !bad |=> !pslverr)
    else $error("good address refused");
  AST_RD_UPPER: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read upper bits set");
  AST_RD_HOLD: assert property (pready |=> $stable(prdata))
    else $error("read data moved");
  AST_EN_DRIVES: assert property (psel && penable && pready && pwrite && !pslverr
    && paddr[9:2] == FCP_IDX_EN && pwdata[0] |-> ##[1:3] port_oe[0])
    else $error("enabled pin not driven");
endmodule
bind fcp_top fcp_chk i_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .special_mode_flag(special_mode_flag), .port_in(port_in),
  .port_out(port_out), .port_oe(port_oe));
`default_nettype wire

// file: dv/fcp_load.sv
`default_nettype none
module fcp_load (
  input  wire logic       clk,
  input  wire logic [3:0] port_out,
  input  wire logic [3:0] port_oe,
  output logic      [3:0] port_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ext_r = 4'h5;
  // outside level toggles so a released pin never looks steady
  always_ff @(posedge clk) begin
    ext_r <= ~ext_r;
  end
  assign port_in = (port_oe & port_out) | (~port_oe & ext_r);
endmodule
`default_nettype wire

// file: dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [9:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        smode;
  wire logic [3:0] port_in;
  logic [3:0]  port_out;
  logic [3:0]  port_oe;
  logic [31:0] rdat;
  logic        rerr;
  int          error_cnt;
  int          compares;
  fcp_top i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .special_mode_flag(smode), .port_in(port_in),
    .port_out(port_out), .port_oe(port_oe));
  fcp_load i_load (.clk(clk), .port_out(port_out), .port_oe(port_oe), .port_in(port_in));
  // ----
  // bus tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) error_cnt++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, {i, 2'b00}, {24'h0, d});
  endtask
  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    xfer(1'b0, {i, 2'b00}, 32'h0);
    chk(rdat, {24'h0, e});
  endtask
  // count high cycles of pin 0 over ten periods
  task automatic hi_cnt(input int e);
    int c;
    c = 0;
    repeat (20) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      c += int'(port_out[0] === 1'b1);
    end
    chk(c, e);
  endtask
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  // main sequence
  initial begin
    sys_rst <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 10'h000;
    pwdata <= 32'h0;
    smode <= 1'b0;
    error_cnt = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(8'h40, 8'h00);
    wr(8'h41, 8'ha5);
    rdc(8'h41, 8'ha5);
    wr(8'h42, 8'hf0);
    rdc(8'h42, 8'h00);
    wr(8'h40, 8'h38);
    rdc(8'h40, 8'h38);
    wr(8'h43, 8'h15);
    rdc(8'h43, 8'h00);
    wr(8'h44, 8'h23);
    rdc(8'h45, 8'h23);
    xfer(1'b0, 10'h0fc, 32'h0);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0);
    xfer(1'b1, 10'h105, 32'h0);
    chk(rerr, 1'b1);
    rdc(8'h41, 8'ha5);
    smode <= 1'b1;
    wr(8'h43, 8'h15);
    rdc(8'h43, 8'h15);
    wr(8'h55, 8'h08);
    wr(8'h44, 8'h11);
    rdc(8'h45, 8'h23);
    wr(8'h55, 8'h00);
    smode <= 1'b0;
    wr(8'h40, 8'h00);
    wr(8'h4c, 8'h03);
    wr(8'h50, 8'h00);
    wr(8'h41, 8'h01);
    wr(8'h42, 8'h01);
    hi_cnt(10);
    chk(port_oe, 4'h1);
    rdc(8'h57, 8'h00);
    wr(8'h41, 8'h00);
    hi_cnt(30);
    wr(8'h50, 8'h02);
    hi_cnt(10);
    wr(8'h42, 8'h00);
    repeat (3) @(posedge clk);
    chk(port_oe, 4'h0);
    wr(8'h48, 8'h00);
    rdc(8'h48, 8'h00);
    wr(8'h57, 8'h02);
    repeat (3) @(posedge clk);
    chk(port_oe, 4'h2);
    wr(8'h56, 8'h02);
    wr(8'h57, 8'h0f);
    repeat (2) @(posedge clk);
    chk(port_out, 4'h2);
    rdc(8'h56, 8'h02);
    wr(8'h57, 8'h00);
    wr(8'h40, 8'h40);
    wr(8'h4c, 8'h00);
    wr(8'h4d, 8'h03);
    wr(8'h50, 8'h00);
    wr(8'h51, 8'h00);
    wr(8'h41, 8'h01);
    wr(8'h42, 8'h01);
    hi_cnt(10);
    chk(port_oe, 4'h1);
    wr(8'h40, 8'h80);
    wr(8'h41, 8'h04);
    wr(8'h42, 8'h04);
    repeat (3) @(posedge clk);
    chk(port_oe, 4'h4);
    close_out();
  end
endmodule
`default_nettype wire
